// File: verilog/irq_driveback_defines.svh
`ifndef IRQ_DRIVEBACK_DEFINES_SVH
`define IRQ_DRIVEBACK_DEFINES_SVH

// Bus signalling levels.
`define REQ_ASSERT      1'b0
`define REQ_RELEASE     1'b1
// I/O write command on the command/byte-enable lines.
`define CMD_IO_WRITE    4'h3
`define BE_ALL_BYTES    4'h0
// Offset of the second data phase from the driveback base.
`define PHASE2_OFFSET   32'h0000_0004
// Layout of the first data word.
`define LINE_LEVEL_LSB  0
`define LINE_ENABLE_LSB 16
// Interrupt bits with a fixed meaning at the host.
`define LINE_SMI        2
`define LINE_NMI        13
// Layout of the second data word.
`define PCI_LEVEL_LSB   0
`define PCI_LEVEL_W     4
`define PM_EVENT_LSB    4
`define PM_EVENT_W      4
`define PHASE2_EN_LSB   16
`define PHASE2_USED_W   8
// Reset values.
`define LEVELS_RESET    16'h0000
`define PHASE2_RESET    8'h00

`endif

// File: verilog/irq_driveback_pkg.sv
package irq_driveback_pkg;
   typedef enum logic [7:0] {
      ST_IDLE   = 8'h01,
      ST_PULSE  = 8'h02,
      ST_GAP    = 8'h04,
      ST_HOLD   = 8'h08,
      ST_ADDR   = 8'h10,
      ST_DATA1  = 8'h20,
      ST_DATA2  = 8'h40,
      ST_TURN   = 8'h80
   } drive_state_t;
endpackage

// File: verilog/irq_driveback_messaging.sv
`timescale 1ns/1ps
`include "irq_driveback_defines.svh"

module irq_driveback_messaging
   import irq_driveback_pkg::*;
#(
   parameter int LATCH_GROUPS = 2
) (
   // Clock and reset.
   input  wire logic                          clk,
   input  wire logic                          reset,
   // Driveback address, four configuration bytes.
   input  wire logic [7:0]                    addr_byte0,
   input  wire logic [7:0]                    addr_byte1,
   input  wire logic [7:0]                    addr_byte2,
   input  wire logic [7:0]                    addr_byte3,
   // Interrupt sources and ownership.
   input  wire logic [15:0]                   line_level,
   input  wire logic [15:0]                   line_owned,
   input  wire logic                          expansion_channel_check_n,
   input  wire logic [3:0]                    pci_level_interrupt,
   input  wire logic [3:0]                    pm_event,
   input  wire logic [3:0]                    pci_level_owned,
   input  wire logic [3:0]                    pm_event_owned,
   input  wire logic                          phase2_enable,
   // Dynamic latch group assignment.
   input  wire logic [LATCH_GROUPS-1:0]       group_assigned,
   // Bus arbitration.
   output logic                               bus_req_n,
   input  wire logic                          bus_gnt_n,
   // Bus cycle drive.
   output logic [31:0]                        ad_out,
   output logic                               ad_oe,
   output logic [3:0]                         cbe_out,
   output logic                               cbe_oe,
   output logic                               frame_n_out,
   output logic                               frame_oe,
   output logic                               irdy_n_out,
   output logic                               irdy_oe,
   input  wire logic                          trdy_n,
   // External latch.
   output logic                               interrupt_latch_strobe,
   output logic [LATCH_GROUPS*4-1:0]          latched_level,
   output logic [LATCH_GROUPS-1:0]            group_drive_en,
   // Status.
   output logic                               busy
);
   import irq_driveback_pkg::*;

   drive_state_t state_reg, state_next;
   logic [15:0] sent1_reg;
   logic [7:0]  sent2_reg;
   logic        only2_reg;
   logic [31:0] ad_reg, ad_next;
   logic [LATCH_GROUPS*4-1:0] latch_reg;

   // Line 13 also carries the expansion channel check as an NMI.
   wire [15:0] levels_now;
   wire [7:0]  phase2_now;
   wire [7:0]  phase2_owned;
   wire [31:0] base_addr;
   wire        change1;
   wire        change2;
   wire        trigger;
   wire        granted;
   wire        target_ready;

   assign base_addr = {addr_byte3, addr_byte2, addr_byte1, addr_byte0};
   assign levels_now = (line_level |
                        (16'(!expansion_channel_check_n) << `LINE_NMI))
                       & line_owned;
   assign phase2_owned = {pm_event_owned, pci_level_owned};
   assign phase2_now = {pm_event, pci_level_interrupt} & phase2_owned;
   assign change1 = levels_now != sent1_reg;
   assign change2 = phase2_enable && (phase2_now != sent2_reg);
   assign trigger = change1 || change2;
   assign granted = bus_gnt_n == 1'b0;
   assign target_ready = trdy_n == 1'b0;

   function automatic logic [31:0] word1(input logic [15:0] lv,
                                         input logic [15:0] own);
      word1 = {~own, lv};
   endfunction

   function automatic logic [31:0] word2(input logic [7:0] lv,
                                         input logic [7:0] own);
      word2 = {8'hFF, ~own, 8'h00, lv};
   endfunction

   always_comb begin
      state_next = state_reg;
      ad_next = ad_reg;
      case (state_reg)
         ST_IDLE: begin
            if (trigger) begin
               state_next = ST_PULSE;
            end
         end
         ST_PULSE: state_next = ST_GAP;
         ST_GAP: state_next = ST_HOLD;
         ST_HOLD: begin
            if (granted) begin
               state_next = ST_ADDR;
               // Second phase alone goes straight to base plus four.
               if (!change1 && change2) begin
                  ad_next = base_addr + `PHASE2_OFFSET;
               end else begin
                  ad_next = base_addr;
               end
            end
         end
         ST_ADDR: begin
            state_next = only2_reg ? ST_DATA2 : ST_DATA1;
            // Levels are sampled here, so late changes still go out.
            ad_next = only2_reg ? word2(phase2_now, phase2_owned)
                                : word1(levels_now, line_owned);
         end
         ST_DATA1: begin
            if (target_ready) begin
               if (phase2_enable) begin
                  state_next = ST_DATA2;
                  ad_next = word2(phase2_now, phase2_owned);
               end else begin
                  state_next = ST_TURN;
               end
            end
         end
         ST_DATA2: begin
            if (target_ready) begin
               state_next = ST_TURN;
            end
         end
         ST_TURN: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         ad_reg <= 32'h0000_0000;
         sent1_reg <= `LEVELS_RESET;
         sent2_reg <= `PHASE2_RESET;
         only2_reg <= 1'b0;
         latch_reg <= '0;
      end else begin
         state_reg <= state_next;
         ad_reg <= ad_next;
         if (state_reg == ST_HOLD && granted) begin
            only2_reg <= !change1 && change2;
         end
         if (state_reg == ST_DATA1 && target_ready) begin
            sent1_reg <= ad_reg[15:0];
            latch_reg <= ad_reg[LATCH_GROUPS*4-1:0];
         end
         if (state_reg == ST_DATA2 && target_ready) begin
            sent2_reg <= ad_reg[7:0];
         end
      end
   end

   // Request is released as soon as the address phase starts.
   assign bus_req_n = (state_reg == ST_PULSE || state_reg == ST_HOLD)
                      ? `REQ_ASSERT : `REQ_RELEASE;
   assign ad_out = ad_reg;
   assign ad_oe = state_reg == ST_ADDR || state_reg == ST_DATA1 ||
                  state_reg == ST_DATA2;
   assign cbe_out = (state_reg == ST_ADDR) ? `CMD_IO_WRITE : `BE_ALL_BYTES;
   assign cbe_oe = ad_oe;
   // Frame goes high on the final data phase.
   assign frame_n_out = !(state_reg == ST_ADDR ||
                          (state_reg == ST_DATA1 && phase2_enable));
   assign frame_oe = ad_oe || state_reg == ST_TURN;
   assign irdy_n_out = !(state_reg == ST_DATA1 || state_reg == ST_DATA2);
   assign irdy_oe = frame_oe && state_reg != ST_ADDR || state_reg == ST_ADDR;
   assign interrupt_latch_strobe = state_reg == ST_TURN;
   // Lines above the latch width never reach the expansion bus this way.
   assign latched_level = latch_reg;
   assign group_drive_en = group_assigned;
   assign busy = state_reg != ST_IDLE;

   property p_req_pattern;
      @(posedge clk) disable iff (reset)
      state_reg == ST_IDLE && trigger |=> !bus_req_n ##1 bus_req_n ##1
      !bus_req_n;
   endproperty
   a_req_pattern: assert property (p_req_pattern)
      else $error("request pattern wrong");

   property p_hold;
      @(posedge clk) disable iff (reset)
      state_reg == ST_HOLD && !granted |=> !bus_req_n;
   endproperty
   a_hold: assert property (p_hold)
      else $error("request dropped before grant");

   property p_write;
      @(posedge clk) disable iff (reset)
      state_reg == ST_HOLD && granted |=> bus_req_n && cbe_out == `CMD_IO_WRITE
      && ad_oe;
   endproperty
   a_write: assert property (p_write)
      else $error("no io write after grant");

   property p_enables;
      @(posedge clk) disable iff (reset)
      state_reg == ST_DATA1 |-> ad_out[31:16] == ~line_owned;
   endproperty
   a_enables: assert property (p_enables)
      else $error("owned enables not low");

   property p_burst;
      @(posedge clk) disable iff (reset)
      state_reg == ST_DATA1 && target_ready && phase2_enable |=>
      state_reg == ST_DATA2 && ad_out[31:24] == 8'hFF;
   endproperty
   a_burst: assert property (p_burst)
      else $error("second phase not burst");

   property p_nmi;
      @(posedge clk) disable iff (reset)
      state_reg == ST_DATA1 && line_owned[13] && !expansion_channel_check_n
      |-> ad_out[13];
   endproperty
   a_nmi: assert property (p_nmi)
      else $error("channel check not on line 13");

   property p_latch;
      @(posedge clk) disable iff (reset)
      interrupt_latch_strobe |-> $past(state_reg) != ST_IDLE;
   endproperty
   a_latch: assert property (p_latch)
      else $error("strobe outside cycle");

   property p_group;
      @(posedge clk) disable iff (reset)
      group_drive_en == group_assigned;
   endproperty
   a_group: assert property (p_group)
      else $error("group drive mismatch");

   property p_idle_quiet;
      @(posedge clk) disable iff (reset)
      state_reg == ST_IDLE |-> bus_req_n && !ad_oe && !frame_oe;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("bus driven while idle");

   property p_addr_base;
      @(posedge clk) disable iff (reset)
      state_reg == ST_ADDR && !only2_reg |-> ad_out == base_addr;
   endproperty
   a_addr_base: assert property (p_addr_base)
      else $error("driveback address wrong");

   property p_addr_alone;
      @(posedge clk) disable iff (reset)
      state_reg == ST_ADDR && only2_reg |->
      ad_out == base_addr + `PHASE2_OFFSET;
   endproperty
   a_addr_alone: assert property (p_addr_alone)
      else $error("stand-alone second phase not at base plus four");

   property p_data_hold;
      @(posedge clk) disable iff (reset)
      (state_reg == ST_DATA1 || state_reg == ST_DATA2) && !target_ready
      |=> $stable(ad_out) && $stable(state_reg);
   endproperty
   a_data_hold: assert property (p_data_hold)
      else $error("data changed before target ready");

   property p_last_phase;
      @(posedge clk) disable iff (reset)
      state_reg == ST_DATA2 || (state_reg == ST_DATA1 && !phase2_enable)
      |-> frame_n_out && !irdy_n_out;
   endproperty
   a_last_phase: assert property (p_last_phase)
      else $error("frame still low on final data phase");

   property p_word2;
      @(posedge clk) disable iff (reset)
      state_reg == ST_DATA2 |->
      ad_out[23:16] == ~phase2_owned && ad_out[15:8] == 8'h00;
   endproperty
   a_word2: assert property (p_word2)
      else $error("second word layout wrong");

   property p_strobe_pulse;
      @(posedge clk) disable iff (reset)
      interrupt_latch_strobe |=> !interrupt_latch_strobe;
   endproperty
   a_strobe_pulse: assert property (p_strobe_pulse)
      else $error("latch strobe longer than one clock");
endmodule // irq_driveback_messaging

// File: testbench/host_arbiter_model.sv
`timescale 1ns/1ps
// Host arbiter and driveback target; grant and ready are paced by the bench.
module host_arbiter_model (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        reset,
   // Pacing.
   input  wire logic [3:0]  gnt_delay,
   input  wire logic [3:0]  trdy_wait,
   input  wire logic [31:0] base_addr,
   // Resolved bus lines.
   input  wire logic        bus_req_n,
   output logic             bus_gnt_n,
   input  wire logic [31:0] ad_bus,
   input  wire logic [3:0]  cbe_bus,
   input  wire logic        frame_n,
   input  wire logic        irdy_n,
   output logic             trdy_n,
   // Words taken by the host.
   output logic             word_valid,
   output logic [31:0]      word_addr,
   output logic [31:0]      word_data,
   output logic [3:0]       word_cmd,
   // Interrupt state kept by the host.
   output logic [15:0]      host_lines,
   output logic [3:0]       pci_active,
   output logic [7:0]       smi_edges,
   output logic [7:0]       nmi_edges
);
   logic [1:0]  req_hist;
   logic [3:0]  gnt_cnt;
   logic [3:0]  wait_cnt;
   logic        armed;
   logic [31:0] next_addr;
   logic [3:0][2:0] share_cnt;
   logic [15:0] new_lines, rise;
   logic [3:0]  p2_up, p2_down;

   assign new_lines = (host_lines & ad_bus[31:16]) |
                      (ad_bus[15:0] & ~ad_bus[31:16]);
   assign rise      = new_lines & ~host_lines;
   assign p2_up     = ~ad_bus[19:16] & ad_bus[3:0];
   assign p2_down   = ~ad_bus[19:16] & ~ad_bus[3:0];
   assign pci_active = {share_cnt[3] != 3'h0, share_cnt[2] != 3'h0,
                        share_cnt[1] != 3'h0, share_cnt[0] != 3'h0};

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         {req_hist, bus_gnt_n, trdy_n} <= 4'hF;
         {armed, word_valid, gnt_cnt, wait_cnt} <= 10'h000;
         {word_addr, word_data, next_addr, word_cmd} <= 100'h0;
         {host_lines, smi_edges, nmi_edges, share_cnt} <= 44'h0;
      end else begin
         req_hist   <= {req_hist[0], bus_req_n};
         word_valid <= 1'b0;
         if (req_hist == 2'h1 && !bus_req_n) begin
            armed   <= 1'b1;
            gnt_cnt <= 4'h0;
         end
         // The delay stands for the previous owner leaving the bus.
         if (armed && bus_gnt_n) begin
            if (gnt_cnt >= gnt_delay) bus_gnt_n <= 1'b0;
            else gnt_cnt <= gnt_cnt + 4'h1;
         end
         if (!frame_n && irdy_n && !bus_gnt_n) begin
            bus_gnt_n <= 1'b1;
            armed     <= 1'b0;
            next_addr <= ad_bus;
            word_cmd  <= cbe_bus;
         end
         if (!irdy_n && !trdy_n) begin
            word_valid <= 1'b1;
            word_addr  <= next_addr;
            word_data  <= ad_bus;
            next_addr  <= next_addr + 32'h4;
            trdy_n     <= 1'b1;
            wait_cnt   <= 4'h0;
            if (next_addr == base_addr) begin
               host_lines <= new_lines;
               // Edge-mode lines request only on a rising level.
               if (rise[2]) smi_edges <= smi_edges + 8'h1;
               if (rise[13]) nmi_edges <= nmi_edges + 8'h1;
            end else begin
               // Shared level lines stay active until the counts balance.
               for (int i = 0; i < 4; i++) begin
                  if (p2_up[i] && share_cnt[i] != 3'h7)
                     share_cnt[i] <= share_cnt[i] + 3'h1;
                  else if (p2_down[i] && share_cnt[i] != 3'h0)
                     share_cnt[i] <= share_cnt[i] - 3'h1;
               end
            end
         end else if (!irdy_n && wait_cnt >= trdy_wait) begin
            trdy_n <= 1'b0;
         end else if (!irdy_n) begin
            wait_cnt <= wait_cnt + 4'h1;
         end else begin
            trdy_n   <= 1'b1;
            wait_cnt <= 4'h0;
         end
      end
   end
endmodule // host_arbiter_model

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
   localparam logic [31:0] BASE = 32'hA5C3_1E40;
   logic        clk, reset, expansion_channel_check_n, phase2_enable;
   logic [7:0]  addr_byte0, addr_byte1, addr_byte2, addr_byte3;
   logic [15:0] line_level, line_owned, prev, lv;
   logic [3:0]  pci_level_interrupt, pm_event, pci_level_owned;
   logic [3:0]  pm_event_owned, cbe_out, cbe_bus, word_cmd;
   logic [3:0]  gnt_delay, trdy_wait;
   logic [1:0]  group_assigned, group_drive_en;
   logic        bus_req_n, bus_gnt_n, ad_oe, cbe_oe, frame_n_out, frame_oe;
   logic        irdy_n_out, irdy_oe, trdy_n, interrupt_latch_strobe, busy;
   logic        word_valid, frame_n, irdy_n;
   logic [31:0] ad_out, ad_bus, word_addr, word_data;
   logic [7:0]  latched_level, exp_latch;
   logic [15:0] host_lines, exp_host;
   logic [3:0]  pci_active, exp_pci;
   logic [7:0]  smi_edges, nmi_edges, exp_smi, exp_nmi;
   logic [31:0] exp_addr[$];
   logic [31:0] exp_data[$];
   int          n_errors = 0;
   int          checks_done = 0;

   // Released address/data and command lines show the inverse, so stale data cannot pass for a match.
   assign ad_bus  = ad_oe ? ad_out : ~ad_out;
   assign cbe_bus = cbe_oe ? cbe_out : ~cbe_out;
   assign frame_n = frame_oe ? frame_n_out : 1'b1;
   assign irdy_n  = irdy_oe ? irdy_n_out : 1'b1;

   irq_driveback_messaging #(.LATCH_GROUPS(2)) irq_driveback_messaging_inst (
      .clk, .reset, .addr_byte0, .addr_byte1, .addr_byte2, .addr_byte3,
      .line_level, .line_owned, .expansion_channel_check_n,
      .pci_level_interrupt, .pm_event, .pci_level_owned, .pm_event_owned,
      .phase2_enable, .group_assigned, .bus_req_n, .bus_gnt_n, .ad_out,
      .ad_oe, .cbe_out, .cbe_oe, .frame_n_out, .frame_oe, .irdy_n_out,
      .irdy_oe, .trdy_n, .interrupt_latch_strobe, .latched_level,
      .group_drive_en, .busy);

   host_arbiter_model host_arbiter_model_inst (.clk, .reset, .gnt_delay,
      .trdy_wait, .bus_req_n, .bus_gnt_n, .ad_bus, .cbe_bus, .frame_n,
      .irdy_n, .trdy_n, .word_valid, .word_addr, .word_data, .word_cmd,
      .base_addr(BASE), .host_lines, .pci_active, .smi_edges, .nmi_edges);

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
         n_errors++;
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wait_busy(input logic v, input int lim);
      for (int i = 0; i < lim && busy !== v; i++) @(negedge clk);
      if (busy !== v) begin
         chk({31'h0, busy}, {31'h0, v});
         conclude();
      end
   endtask

   // A nonzero late value replaces the levels while the request is pending.
   task automatic run(input logic [15:0] lv, input logic [15:0] late,
                      input logic [3:0] pci, input logic [3:0] pm,
                      input logic p2, input logic w1, input logic w2,
                      input logic ck);
      logic [15:0] fin;
      fin = (late !== 16'h0000) ? late : lv;
      fin[13] = fin[13] | ~ck;
      fin = fin & line_owned;
      if (w1) begin
         if (fin[2] && !exp_host[2]) exp_smi++;
         if (fin[13] && !exp_host[13]) exp_nmi++;
         exp_host = fin;
         exp_addr.push_back(BASE);
         exp_data.push_back({~line_owned, fin});
         exp_latch = fin[7:0];
      end
      if (w2) begin
         exp_pci = pci & pci_level_owned;
         exp_addr.push_back(BASE + 32'h4);
         exp_data.push_back({8'hFF, ~pm_event_owned, ~pci_level_owned,
                             8'h00, pm, pci});
      end
      @(negedge clk);
      line_level = lv;
      pci_level_interrupt = pci;
      pm_event = pm;
      phase2_enable = p2;
      expansion_channel_check_n = ck;
      gnt_delay = (late !== 16'h0000) ? 4'hF : 4'($urandom_range(15));
      trdy_wait = 4'($urandom_range(3));
      group_assigned = 2'($urandom);
      if (late !== 16'h0000) begin
         repeat (2) @(negedge clk);
         line_level = late;
      end
      wait_busy(1'b1, 20);
      wait_busy(1'b0, 300);
      repeat (3) @(negedge clk);
      chk(32'(exp_addr.size()), 32'h0);
      chk({30'h0, group_drive_en}, {30'h0, group_assigned});
      chk({16'h0, host_lines}, {16'h0, exp_host});
      chk({28'h0, pci_active}, {28'h0, exp_pci});
      chk({16'h0, smi_edges, nmi_edges}, {16'h0, exp_smi, exp_nmi});
      $display("test done: levels %h phase2 %h", fin, {pm, pci});
   endtask

   always @(negedge clk) begin
      if (word_valid === 1'b1) begin
         chk(32'(exp_addr.size() != 0), 32'h1);
         if (exp_addr.size() != 0) begin
            chk(word_addr, exp_addr.pop_front());
            chk(word_data, exp_data.pop_front());
            chk({28'h0, word_cmd}, 32'h3);
            chk({31'h0, bus_req_n}, 32'h1);
         end
      end
      if (interrupt_latch_strobe === 1'b1) begin
         chk({24'h0, latched_level}, {24'h0, exp_latch});
      end
   end

   initial begin
      {reset, expansion_channel_check_n} = 2'h3;
      {phase2_enable, line_level, pci_level_interrupt, pm_event} = 25'h0;
      {gnt_delay, trdy_wait, group_assigned, exp_latch} = 18'h0;
      {exp_host, exp_pci, exp_smi, exp_nmi} = 36'h0;
      {addr_byte3, addr_byte2, addr_byte1, addr_byte0} = BASE;
      line_owned = 16'h202C;
      pci_level_owned = 4'h7;
      pm_event_owned = 4'hC;
      void'($urandom(2));
      repeat (2) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      chk({31'h0, bus_req_n}, 32'h1);
      chk({31'h0, ad_oe}, 32'h0);
      chk({31'h0, interrupt_latch_strobe}, 32'h0);
      run(16'h0008, 16'h0, 4'h0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b1);
      run(16'h0028, 16'h0, 4'h0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b1);
      run(16'h0020, 16'h0, 4'h0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b1);
      run(16'h0024, 16'h0, 4'h0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b1);
      run(16'h0024, 16'h0, 4'h0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0);
      run(16'h0004, 16'h0, 4'h0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b1);
      run(16'h0008, 16'h0, 4'h5, 4'h8, 1'b1, 1'b1, 1'b1, 1'b1);
      run(16'h0008, 16'h0, 4'h2, 4'h8, 1'b1, 1'b0, 1'b1, 1'b1);
      run(16'h0028, 16'h0024, 4'h2, 4'h8, 1'b0, 1'b1, 1'b0, 1'b1);
      prev = 16'h0024;
      for (int k = 0; k < 6; k++) begin
         lv = prev ^ (16'($urandom) & line_owned);
         if (lv == prev) lv = prev ^ 16'h0008;
         run(lv, 16'h0, 4'h2, 4'h8, 1'b0, 1'b1, 1'b0, 1'b1);
         prev = lv;
      end
      conclude();
   end
endmodule // tb
